// [rtl/muldiv_pkg.sv]
// Purpose: shared constants and types of the multiplier/divider control block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   16-bit data sits in the low bits of each word; upper bits read zero
package muldiv_pkg;

    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam logic [4:0] CTRL_OFS     = 5'h00;
    localparam logic [4:0] OPA_LO_OFS   = 5'h04;
    localparam logic [4:0] OPA_HI_OFS   = 5'h08;
    localparam logic [4:0] OPB_OFS      = 5'h0c;
    localparam logic [4:0] REM_OFS      = 5'h10;
    localparam logic [4:0] IRQ_STAT_OFS = 5'h14;
    localparam logic [4:0] IRQ_CLR_OFS  = 5'h18;
    localparam logic [4:0] IRQ_EN_OFS   = 5'h1c;

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    localparam int          ACTIVE_BIT    = 7;
    localparam int          MODE_BIT      = 0;
    localparam int          DONE_BIT      = 0;
    localparam logic [15:0] DATA_RST      = 16'h0000;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // timing: iteration counts per operation
    // ------------------------------------------------------------------
    localparam logic [5:0]  MUL_STEPS     = 6'h10;
    localparam logic [5:0]  DIV_STEPS     = 6'h20;

    typedef enum logic {
        MODE_DIV,
        MODE_MUL
    } op_mode_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } av_req_t;

endpackage : muldiv_pkg

// [rtl/muldiv_ctrl.sv]
// Purpose: multiplier/divider with operand, result and remainder control
// Assumes: single 20 MHz clock, synchronous active-high reset, Avalon-MM slave
// Notes:   16x16 multiply in 16 steps, 32/16 divide in 32 steps
//
// How it works
// [RULE_01] Software keeps the two-wire serial unit idle while this unit is used, since they share request flags.
// [RULE_02] A remainder read while the operation runs returns whatever the register holds at that moment.
// [RULE_03] Starting an operation clears the remainder register.
// [RULE_04] Starting in multiply mode clears the upper half of operand/result A.
// [RULE_05] A write to operand A during a run is taken but the run continues with an undefined result.
// [RULE_06] An operand A read during a run returns the live, intermediate contents.
// [RULE_07] A write to operand B during a run is taken but the run continues with an undefined result.
// [RULE_08] Division by zero is not trapped and leaves undefined quotient and remainder.
// [RULE_09] Clearing the active bit aborts the run unless it finishes in that cycle, which then completes.
// [RULE_10] Completion clears the active bit and sets the completion flag.
`timescale 1ns/1ps

module muldiv_ctrl
    import muldiv_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        srst_i,
    input  wire logic [4:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    output logic [31:0]      readdata_o,
    output logic             waitrequest_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    av_req_t     req;
    wire         req_any;
    wire         wr_acc;
    wire         rd_cap;
    wire         ctrl_wr;
    wire         opa_lo_wr;
    wire         opa_hi_wr;
    wire         opb_wr;
    wire         clr_wr;
    wire         en_wr;

    assign req       = '{read: read_i, write: write_i, address: address_i, writedata: writedata_i};
    assign req_any   = req.read | req.write;
    // writes land on the edge that also sees waitrequest low
    assign wr_acc    = req.write & ~waitrequest_o;
    assign rd_cap    = req.read & waitrequest_o;
    assign ctrl_wr   = wr_acc && (req.address == CTRL_OFS);
    assign opa_lo_wr = wr_acc && (req.address == OPA_LO_OFS);
    assign opa_hi_wr = wr_acc && (req.address == OPA_HI_OFS);
    assign opb_wr    = wr_acc && (req.address == OPB_OFS);
    assign clr_wr    = wr_acc && (req.address == IRQ_CLR_OFS);
    assign en_wr     = wr_acc && (req.address == IRQ_EN_OFS);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic        active;
    op_mode_t    mode;
    logic [5:0]  step_cnt;
    logic [31:0] opa;
    logic [15:0] opb;
    logic [15:0] rem;
    logic        irq_stat;
    logic        irq_en;

    // ------------------------------------------------------------------
    // datapath
    // ------------------------------------------------------------------
    wire [16:0]  mul_sum;
    wire [31:0]  next_a_mul;
    wire [16:0]  div_shift;
    wire         div_ge;
    wire [16:0]  div_diff;
    wire [15:0]  next_rem_div;
    wire [31:0]  next_a_div;
    wire [5:0]   step_limit;
    wire         last_step;
    wire         done;
    wire         start;
    wire         abort;

    // shift-add: upper half accumulates, lower half shifts out the multiplier
    assign mul_sum      = opa[0] ? ({1'b0, opa[31:16]} + {1'b0, opb}) : {1'b0, opa[31:16]};
    assign next_a_mul   = {mul_sum, opa[15:1]};
    // restoring divide; a zero divisor just yields all-ones quotient, no trap
    assign div_shift    = {rem, opa[31]};
    assign div_ge       = div_shift >= {1'b0, opb};       // [RULE_08]
    assign div_diff     = div_shift - {1'b0, opb};
    assign next_rem_div = div_ge ? div_diff[15:0] : div_shift[15:0];
    assign next_a_div   = {opa[30:0], div_ge};

    assign step_limit   = (mode == MODE_MUL) ? MUL_STEPS : DIV_STEPS;
    assign last_step    = active && (step_cnt == step_limit - 6'h01);
    assign done         = last_step;                      // [RULE_09]
    assign start        = ctrl_wr && req.writedata[ACTIVE_BIT] && !active;
    // a clear landing on the final step is outrun by completion
    assign abort        = ctrl_wr && !req.writedata[ACTIVE_BIT] && active && !last_step; // [RULE_09]

    // ------------------------------------------------------------------
    // read mux: live values, no hold-off while running
    // ------------------------------------------------------------------
    wire [31:0]  rd_mux;
    wire [15:0]  ctrl_view;

    assign ctrl_view = {8'h00, active, 6'h00, mode == MODE_MUL};
    assign rd_mux    = (req.address == CTRL_OFS)     ? {16'h0000, ctrl_view} :
                       (req.address == OPA_LO_OFS)   ? {16'h0000, opa[15:0]} :   // [RULE_06]
                       (req.address == OPA_HI_OFS)   ? {16'h0000, opa[31:16]} :  // [RULE_06]
                       (req.address == OPB_OFS)      ? {16'h0000, opb} :
                       (req.address == REM_OFS)      ? {16'h0000, rem} :         // [RULE_02]
                       (req.address == IRQ_STAT_OFS) ? {31'h0, irq_stat} :
                       (req.address == IRQ_EN_OFS)   ? {31'h0, irq_en} :
                       RDATA_RST;

    // ------------------------------------------------------------------
    // bus handshake: one wait state on every access
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            waitrequest_o <= 1'b1;
            readdata_o    <= RDATA_RST;
        end else begin
            waitrequest_o <= !(req_any && waitrequest_o);
            if (rd_cap) begin
                readdata_o <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            active   <= 1'b0;
            mode     <= MODE_DIV;
            step_cnt <= 6'h00;
        end else if (start) begin
            active   <= 1'b1;
            mode     <= req.writedata[MODE_BIT] ? MODE_MUL : MODE_DIV;
            step_cnt <= 6'h00;
        end else if (done || abort) begin
            active   <= 1'b0;                             // [RULE_10]
        end else if (active) begin
            step_cnt <= step_cnt + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // operand, result and remainder registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            opa <= {DATA_RST, DATA_RST};
            opb <= DATA_RST;
            rem <= DATA_RST;
        end else begin
            if (active && !abort) begin
                opa <= (mode == MODE_MUL) ? next_a_mul : next_a_div;
                if (mode == MODE_DIV) begin
                    rem <= next_rem_div;
                end
            end
            if (start) begin
                rem <= DATA_RST;                          // [RULE_03]
                if (req.writedata[MODE_BIT]) begin
                    opa[31:16] <= DATA_RST;               // [RULE_04]
                end
            end
            // software writes win over the step; the run carries on regardless
            if (opa_lo_wr) begin
                opa[15:0] <= req.writedata[15:0];         // [RULE_05]
            end
            if (opa_hi_wr) begin
                opa[31:16] <= req.writedata[15:0];        // [RULE_05]
            end
            if (opb_wr) begin
                opb <= req.writedata[15:0];               // [RULE_07]
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt: sticky status, write-one-to-clear, enable, level output
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_stat <= 1'b0;
            irq_en   <= 1'b0;
            irq_o    <= 1'b0;
        end else begin
            // set beats a clear landing in the same cycle
            if (done) begin
                irq_stat <= 1'b1;                         // [RULE_10]
            end else if (clr_wr && req.writedata[DONE_BIT]) begin
                irq_stat <= 1'b0;
            end
            if (en_wr) begin
                irq_en <= req.writedata[DONE_BIT];
            end
            irq_o <= irq_stat & irq_en;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic ctrl_touched;

    // marks a cut run; kept until a completion, as a cut divide may restart before its own deadline
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || done) begin
            ctrl_touched <= 1'b0;
        end else if (abort) begin
            ctrl_touched <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_start_mul;
        start && req.writedata[MODE_BIT];
    endsequence

    sequence s_quiet16;
        (!ctrl_wr)[*8] ##1 (!ctrl_wr)[*8];
    endsequence

    AST_START_CLEARS_REM: assert property (start |=> rem == DATA_RST) // [RULE_03]
        else $error("remainder not cleared at start");
    AST_MUL_CLEARS_UPPER: assert property (s_start_mul |=> opa[31:16] == DATA_RST) // [RULE_04]
        else $error("upper half of operand A not cleared on multiply start");
    AST_MUL_COMPLETES: assert property (s_start_mul ##1 s_quiet16 |=> !active && irq_stat) // [RULE_10]
        else $error("multiply did not finish after sixteen steps");
    AST_DIV_COMPLETES: assert property ((start && !req.writedata[MODE_BIT]) // [RULE_10]
        |-> ##33 (!active || ctrl_touched))
        else $error("divide did not finish after thirty-two steps");
    AST_ABORT_STOPS: assert property (abort |=> !active && $stable(irq_stat)) // [RULE_09]
        else $error("clearing the active bit did not stop the run");
    AST_CLEAR_ON_LAST: assert property ((ctrl_wr && !req.writedata[ACTIVE_BIT] && last_step) |=> irq_stat) // [RULE_09]
        else $error("completion lost under a simultaneous clear");
    AST_A_WRITE_RUNS: assert property (((opa_lo_wr || opa_hi_wr) && active && !last_step && !ctrl_wr) // [RULE_05]
        |=> active)
        else $error("operand A write stopped the run");
    AST_B_WRITE_RUNS: assert property ((opb_wr && active && !last_step && !ctrl_wr) |=> active) // [RULE_07]
        else $error("operand B write stopped the run");
    AST_REM_READ_IDLE: assert property ((rd_cap && req.address == REM_OFS && !active) // [RULE_02]
        |=> readdata_o == {16'h0000, $past(rem)})
        else $error("idle remainder read returned a wrong value");
    AST_IRQ_PATH: assert property ((done && irq_en && !en_wr) |-> ##2 irq_o) // [RULE_10]
        else $error("enabled completion did not raise the interrupt");
    AST_ONE_WAIT: assert property ((req_any && waitrequest_o) |=> !waitrequest_o ##1 waitrequest_o)
        else $error("access not answered after one wait state");
    AST_IDLE_NO_ACK: assert property ((!req_any && waitrequest_o) |=> waitrequest_o)
        else $error("access answered with no request pending");
    AST_READ_CAPTURE: assert property (rd_cap |=> readdata_o == $past(rd_mux))
        else $error("read data not taken from the addressed register");
    AST_RDATA_HOLDS: assert property (!rd_cap |=> $stable(readdata_o))
        else $error("read data moved without a read");

    // ------------------------------------------------------------------
    // sequencer and register checks
    // ------------------------------------------------------------------
    AST_START_SETS_ACTIVE: assert property (start |=> active && step_cnt == 6'h00)
        else $error("start did not raise the active bit");
    AST_STEP_BOUND: assert property (active |-> step_cnt < step_limit) // [RULE_10]
        else $error("step counter ran past the end of the operation");
    AST_RESTART_IGNORED: assert property ((ctrl_wr && req.writedata[ACTIVE_BIT] && active && !last_step)
        |=> active && $stable(mode))
        else $error("start request while running disturbed the run");
    AST_ABORT_FREEZES: assert property (abort |=> $stable(opa) && $stable(rem)) // [RULE_09]
        else $error("cut run still stepped the operands");
    AST_MUL_KEEPS_REM: assert property ((active && mode == MODE_MUL) |=> $stable(rem)) // [RULE_03]
        else $error("multiply disturbed the cleared remainder");
    // restoring steps keep the remainder below a nonzero divisor left alone by software
    AST_DIV_REM_BELOW: assert property ((done && mode == MODE_DIV && opb != DATA_RST && !opb_wr) // [RULE_08]
        |=> rem < opb)
        else $error("divide left a remainder not below the divisor");
    AST_OPA_LO_WRITE: assert property (opa_lo_wr |=> opa[15:0] == $past(req.writedata[15:0])) // [RULE_05]
        else $error("operand A write not taken");
    AST_OPB_WRITE: assert property (opb_wr |=> opb == $past(req.writedata[15:0])) // [RULE_07]
        else $error("operand B write not taken");

    // ------------------------------------------------------------------
    // interrupt checks
    // ------------------------------------------------------------------
    wire         flag_clr;

    assign flag_clr = clr_wr && req.writedata[DONE_BIT];

    AST_SET_WINS: assert property ((done && flag_clr) |=> irq_stat) // [RULE_10]
        else $error("completion lost under a simultaneous flag clear");
    AST_FLAG_CLEARS: assert property ((flag_clr && !done) |=> !irq_stat)
        else $error("flag clear had no effect");
    AST_EN_WRITE: assert property (en_wr |=> irq_en == $past(req.writedata[DONE_BIT]))
        else $error("enable write not taken");
    AST_IRQ_LEVEL: assert property (irq_o == $past(irq_stat && irq_en)) // [RULE_10]
        else $error("interrupt output does not follow enabled status");

endmodule : muldiv_ctrl

// [verif/test_muldiv_ctrl.sv]
// Purpose: self-checking bench for the multiplier/divider control block
// Assumes: Avalon-MM access with one wait cycle, single 20 MHz clock
// Notes:   results are only read once the active bit has dropped
`timescale 1ns/1ps

module test_muldiv_ctrl;
    import muldiv_pkg::*;

    logic        sys_clk_i;
    logic        srst_i;
    logic [4:0]  address_i;
    logic        read_i;
    logic        write_i;
    logic [31:0] writedata_i;
    logic [31:0] readdata_o;
    logic        waitrequest_o;
    logic        irq_o;
    int          err_total;
    int          tests_run;
    logic [31:0] rd;

    muldiv_ctrl muldiv_ctrl_i (
        .sys_clk_i     (sys_clk_i),
        .srst_i        (srst_i),
        .address_i     (address_i),
        .read_i        (read_i),
        .write_i       (write_i),
        .writedata_i   (writedata_i),
        .readdata_o    (readdata_o),
        .waitrequest_o (waitrequest_o),
        .irq_o         (irq_o)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // ------------------------------------------------------------------
    // closing, compare and bus tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // request held until waitrequest is seen low; bounded wait
    task automatic bus_access(input logic wr, input logic [4:0] addr, input logic [31:0] data);
        int n;
        @(posedge sys_clk_i);
        read_i      <= ~wr;
        write_i     <= wr;
        address_i   <= addr;
        writedata_i <= data;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk_i);
            if (waitrequest_o === 1'b0) break;
        end
        rd = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
        if (n == 20) begin
            err_total++;
            $display("CHECK FAILED at %0t: bus access never answered", $time);
            end_of_test();
        end
    endtask : bus_access

    task automatic bus_write(input logic [4:0] addr, input logic [31:0] data);
        bus_access(1'b1, addr, data);
    endtask : bus_write

    task automatic bus_read(input logic [4:0] addr, output logic [31:0] data);
        bus_access(1'b0, addr, 32'h0000_0000);
        data = rd;
    endtask : bus_read

    // poll the active bit; a run never takes more than a few dozen cycles
    task automatic wait_done();
        int n;
        for (n = 0; n < 60; n++) begin
            bus_read(CTRL_OFS, rd);
            if (rd[ACTIVE_BIT] === 1'b0) break;
        end
        if (n == 60) begin
            err_total++;
            $display("CHECK FAILED at %0t: operation never finished", $time);
            end_of_test();
        end
    endtask : wait_done

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        err_total = 0;
        tests_run = 0;
        srst_i = 1'b1;
        read_i = 1'b0;
        write_i = 1'b0;
        address_i = 5'h00;
        writedata_i = 32'h0000_0000;
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        @(posedge sys_clk_i);
        check({31'h0, irq_o}, 32'h0000_0000, "irq after reset");
        bus_read(CTRL_OFS, rd);     check(rd, 32'h0000_0000, "ctrl reset");
        bus_read(REM_OFS, rd);      check(rd, 32'h0000_0000, "remainder reset");
        bus_read(5'h1e, rd);        check(rd, 32'h0000_0000, "unmapped read");
        // completion flags are this unit's alone; no two-wire serial traffic runs beside it
        bus_write(IRQ_EN_OFS, 32'h0000_0001);
        // divide 100 / 7 -> quotient 14, remainder 2
        bus_write(OPA_HI_OFS, 32'h0000_0000);
        bus_write(OPA_LO_OFS, 32'h0000_0064);
        bus_write(OPB_OFS, 32'h0000_0007);
        bus_write(CTRL_OFS, 32'h0000_0080);
        wait_done();
        check(rd, 32'h0000_0000, "ctrl after divide");
        bus_read(IRQ_STAT_OFS, rd); check(rd, 32'h0000_0001, "done flag after divide");
        repeat (2) @(posedge sys_clk_i);
        check({31'h0, irq_o}, 32'h0000_0001, "irq on completion");
        bus_read(OPA_LO_OFS, rd);   check(rd, 32'h0000_000e, "quotient");
        bus_read(REM_OFS, rd);      check(rd, 32'h0000_0002, "remainder");
        bus_write(IRQ_STAT_OFS, 32'h0000_0000);
        bus_read(IRQ_STAT_OFS, rd); check(rd, 32'h0000_0001, "status is read-only");
        bus_write(IRQ_CLR_OFS, 32'h0000_0001);
        repeat (2) @(posedge sys_clk_i);
        check({31'h0, irq_o}, 32'h0000_0000, "irq cleared");
        // multiply with a dirty upper half; start must zero it and the remainder
        bus_write(OPA_HI_OFS, 32'h0000_ffff);
        bus_write(OPA_LO_OFS, 32'h0000_ffff);
        bus_write(OPB_OFS, 32'h0000_ffff);
        bus_write(CTRL_OFS, 32'h0000_0081);
        bus_write(CTRL_OFS, 32'h0000_0080); // ignored while running
        wait_done();
        check(rd, 32'h0000_0001, "ctrl after multiply");
        bus_read(OPA_LO_OFS, rd);   check(rd, 32'h0000_0001, "product low");
        bus_read(OPA_HI_OFS, rd);   check(rd, 32'h0000_fffe, "product high");
        bus_read(REM_OFS, rd);      check(rd, 32'h0000_0000, "remainder cleared on start");
        bus_write(IRQ_CLR_OFS, 32'h0000_0001);
        // operand B touched mid-run: the run still ends and flags completion
        bus_write(IRQ_EN_OFS, 32'h0000_0000);
        bus_write(CTRL_OFS, 32'h0000_0081);
        bus_write(OPB_OFS, 32'h0000_0003);
        bus_write(OPA_LO_OFS, 32'h0000_0005);
        wait_done();
        bus_read(IRQ_STAT_OFS, rd); check(rd, 32'h0000_0001, "done after operand change");
        bus_read(OPB_OFS, rd);      check(rd, 32'h0000_0003, "operand B write taken mid-run");
        bus_read(IRQ_EN_OFS, rd);   check(rd, 32'h0000_0000, "enable readback");
        bus_read(IRQ_CLR_OFS, rd);  check(rd, 32'h0000_0000, "clear register reads zero");
        check({31'h0, irq_o}, 32'h0000_0000, "masked irq stays low");
        bus_write(IRQ_CLR_OFS, 32'h0000_0001);
        // abort a divide early: no completion flag
        bus_write(IRQ_EN_OFS, 32'h0000_0001);
        bus_write(CTRL_OFS, 32'h0000_0080);
        bus_write(CTRL_OFS, 32'h0000_0000);
        repeat (40) @(posedge sys_clk_i);
        bus_read(CTRL_OFS, rd);     check(rd, 32'h0000_0000, "active dropped on abort");
        bus_read(IRQ_STAT_OFS, rd); check(rd, 32'h0000_0000, "no flag on abort");
        check({31'h0, irq_o}, 32'h0000_0000, "no irq on abort");
        // clear landing on the final multiply step: completion wins
        bus_write(OPA_LO_OFS, 32'h0000_0003);
        bus_write(OPB_OFS, 32'h0000_0005);
        bus_write(CTRL_OFS, 32'h0000_0081);
        // start lands at edge S; after 13 idle edges the clear lands at S+16, the last step
        repeat (13) @(posedge sys_clk_i);
        bus_write(CTRL_OFS, 32'h0000_0001);
        bus_read(CTRL_OFS, rd);     check(rd, 32'h0000_0001, "ctrl after final-step clear");
        bus_read(IRQ_STAT_OFS, rd); check(rd, 32'h0000_0001, "flag on final-step clear");
        bus_read(OPA_LO_OFS, rd);   check(rd, 32'h0000_000f, "product after final-step clear");
        bus_write(IRQ_CLR_OFS, 32'h0000_0001);
        end_of_test();
    end

endmodule : test_muldiv_ctrl
